// *** hw/dsg_pkg.sv ***
// Package for the deserializer status and pin configuration register bank.
// Assumes a 32-bit AXI4-Lite register bus; each register index is one word.
package dsg_pkg;

  // Register indices; byte address = 4 * index
  localparam logic [5:0] IDX_FREQ_COUNT  = 6'h1b;
  localparam logic [5:0] IDX_GEN_STATUS  = 6'h1c;
  localparam logic [5:0] IDX_PIN0_CFG    = 6'h1d;
  localparam logic [5:0] IDX_PIN12_CFG   = 6'h1e;
  localparam logic [5:0] IDX_PIN3_CFG    = 6'h1f;
  localparam logic [5:0] IDX_PORT_SEL    = 6'h30;
  localparam logic [5:0] IDX_IRQ_STATUS  = 6'h31;
  localparam logic [5:0] IDX_IRQ_CLEAR   = 6'h32;
  localparam logic [5:0] IDX_IRQ_ENABLE  = 6'h33;
  localparam logic [5:0] IDX_PIN_LEVELS  = 6'h34;

  // General status bit positions
  localparam int unsigned ST_LOCK_BIT    = 0;
  localparam int unsigned ST_SIGDET_BIT  = 1;
  localparam int unsigned ST_AUDIO_BIT   = 3;
  localparam int unsigned ST_RX_DUAL_BIT = 4;
  localparam int unsigned ST_TX_DUAL_BIT = 5;

  // Interrupt event bit positions
  localparam int unsigned EV_LOCK_BIT    = 0;
  localparam int unsigned EV_SIGDET_BIT  = 1;
  localparam int unsigned EV_FREQ_BIT    = 2;
  localparam int unsigned EV_W           = 3;

  // Pin configuration nibble: value, remote, direction, enable
  typedef struct packed {
    logic local_value;
    logic remote_control;
    logic direction;
    logic function_enable;
  } dsg_pin_cfg_t;

  // Reset values of the pin nibbles
  localparam dsg_pin_cfg_t PIN0_RST = 4'h3;
  localparam dsg_pin_cfg_t PIN1_RST = 4'h3;
  localparam dsg_pin_cfg_t PIN2_RST = 4'h0;
  localparam dsg_pin_cfg_t PIN3_RST = 4'h2;

  // Link and audio status inputs
  typedef struct packed {
    logic transmit_two_link_flag;
    logic receive_two_link_flag;
    logic audio_pll_locked;
    logic serial_detect;
    logic lock_ch_b;
    logic lock_ch_a;
  } dsg_link_status_t;

  // Periods in ns
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned OSC_PERIOD_NS = 50;
  localparam int unsigned OSC_CYCLES_RAW = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned OSC_CYCLES = (OSC_CYCLES_RAW < 1) ? 1 : OSC_CYCLES_RAW;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** hw/dsg_regs.sv ***
// Register bank for deserializer status, pixel clock frequency counter and
// the first four general purpose pins of both pin ports.
// Assumes AXI4-Lite on aclk; pixel clock and pads asynchronous.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps

module dsg_regs #(
  parameter int unsigned  ADDR_W   = 8,
  parameter logic [3:0]   REVISION = 4'ha  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]          s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Status inputs and pixel clock
  input  wire dsg_pkg::dsg_link_status_t  link_status,
  input  wire logic                       pixel_clock,
  // Pin sources: [3:0] primary pins, [7:4] second port pins
  input  wire logic [7:0]                 functional_value,
  input  wire logic [7:0]                 remote_value,
  // Pads
  input  wire logic [7:0]                 pad_in,
  output logic [7:0]                      pad_out,
  output logic [7:0]                      pad_oe,
  // Interrupt
  output logic                            irq
);

  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) begin
      $error("dsg_regs: ADDR_W must be 8..32");
    end
  end

  // Register index of a byte address
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = ((addr >> 8) == '0) ? addr[7:2] : 6'h3f;
  endfunction

  // Synchronisers for asynchronous inputs
  logic [5:0] stat_s1_reg, stat_s2_reg;
  logic [7:0] pad_s1_reg, pad_s2_reg;
  logic       pix_s1_reg, pix_s2_reg, pix_s3_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_s1_reg <= 6'h00;
      stat_s2_reg <= 6'h00;
      pad_s1_reg  <= 8'h00;
      pad_s2_reg  <= 8'h00;
      pix_s1_reg  <= 1'b0;
      pix_s2_reg  <= 1'b0;
      pix_s3_reg  <= 1'b0;
    end else begin
      stat_s1_reg <= link_status;
      stat_s2_reg <= stat_s1_reg;
      pad_s1_reg  <= pad_in;
      pad_s2_reg  <= pad_s1_reg;
      pix_s1_reg  <= pixel_clock;
      pix_s2_reg  <= pix_s1_reg;
      pix_s3_reg  <= pix_s2_reg;
    end
  end

  dsg_pkg::dsg_link_status_t st;
  logic [7:0] gen_status;
  logic       pix_edge;

  // General status assembly, reserved bits zero
  always_comb begin
    st         = stat_s2_reg;
    gen_status = 8'h00;
    gen_status[dsg_pkg::ST_TX_DUAL_BIT] = st.transmit_two_link_flag;
    gen_status[dsg_pkg::ST_RX_DUAL_BIT] = st.receive_two_link_flag;
    gen_status[dsg_pkg::ST_AUDIO_BIT]   = st.audio_pll_locked;
    gen_status[dsg_pkg::ST_SIGDET_BIT]  = st.serial_detect;
    gen_status[dsg_pkg::ST_LOCK_BIT]    =
      st.lock_ch_a & (st.lock_ch_b | ~st.receive_two_link_flag);
    pix_edge = pix_s2_reg & ~pix_s3_reg;
  end

  // AXI4-Lite write channel state
  logic              aw_hold_reg, aw_hold_next;
  logic              w_hold_reg, w_hold_next;
  logic [5:0]        widx_reg, widx_next;
  logic [7:0]        wdata_reg, wdata_next;
  logic              wlane_reg, wlane_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              do_write;
  logic              wr_hit;

  always_comb begin
    s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
    s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
    do_write      = aw_hold_reg & w_hold_reg;
    aw_hold_next  = aw_hold_reg;
    w_hold_next   = w_hold_reg;
    widx_next     = widx_reg;
    wdata_next    = wdata_reg;
    wlane_next    = wlane_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    case (widx_reg)
      dsg_pkg::IDX_FREQ_COUNT, dsg_pkg::IDX_PIN0_CFG, dsg_pkg::IDX_PIN12_CFG,
      dsg_pkg::IDX_PIN3_CFG, dsg_pkg::IDX_PORT_SEL, dsg_pkg::IDX_IRQ_CLEAR,
      dsg_pkg::IDX_IRQ_ENABLE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      widx_next    = reg_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      wdata_next  = s_axi_wdata[7:0];
      wlane_next  = s_axi_wstrb[0];
    end
    // Apply write once both halves held
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_hit ? dsg_pkg::RESP_OKAY : dsg_pkg::RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      widx_reg    <= 6'h00;
      wdata_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      widx_reg    <= widx_next;
      wdata_reg   <= wdata_next;
      wlane_reg   <= wlane_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // Write strobe per register, low byte lane only
  function automatic logic wr_to(input logic [5:0] idx);
    wr_to = do_write & wlane_reg & (widx_reg == idx);
  endfunction

  // Pin banks, port select, interrupt control
  dsg_pkg::dsg_pin_cfg_t cfg_reg [2][4];
  dsg_pkg::dsg_pin_cfg_t cfg_next [2][4];
  logic                  sel_reg, sel_next;
  logic [dsg_pkg::EV_W-1:0] irq_st_reg, irq_st_next;
  logic [dsg_pkg::EV_W-1:0] irq_en_reg, irq_en_next;
  logic [dsg_pkg::EV_W-1:0] events;
  logic                  prev_lock_reg, prev_sig_reg;
  logic                  freq_done;

  always_comb begin
    cfg_next    = cfg_reg;
    sel_next    = sel_reg;
    irq_en_next = irq_en_reg;
    if (wr_to(dsg_pkg::IDX_PORT_SEL)) begin
      sel_next = wdata_reg[0];
    end
    if (wr_to(dsg_pkg::IDX_PIN0_CFG)) begin
      cfg_next[sel_reg][0] = wdata_reg[3:0];
    end
    // pin 1 low nibble, pin 2 high nibble
    if (wr_to(dsg_pkg::IDX_PIN12_CFG)) begin
      cfg_next[sel_reg][1] = wdata_reg[3:0];
      cfg_next[sel_reg][2] = wdata_reg[7:4];
    end
    if (wr_to(dsg_pkg::IDX_PIN3_CFG)) begin
      cfg_next[sel_reg][3] = wdata_reg[3:0];
    end
    if (wr_to(dsg_pkg::IDX_IRQ_ENABLE)) begin
      irq_en_next = wdata_reg[dsg_pkg::EV_W-1:0];
    end
    // Sticky events; set wins over clear
    events = '0;
    events[dsg_pkg::EV_LOCK_BIT]   = gen_status[dsg_pkg::ST_LOCK_BIT] ^ prev_lock_reg;
    events[dsg_pkg::EV_SIGDET_BIT] = gen_status[dsg_pkg::ST_SIGDET_BIT] ^ prev_sig_reg;
    events[dsg_pkg::EV_FREQ_BIT]   = freq_done;
    irq_st_next = irq_st_reg;
    if (wr_to(dsg_pkg::IDX_IRQ_CLEAR)) begin
      irq_st_next = irq_st_next & ~wdata_reg[dsg_pkg::EV_W-1:0];
    end
    irq_st_next = irq_st_next | events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int b = 0; b < 2; b++) begin
        cfg_reg[b][0] <= dsg_pkg::PIN0_RST;
        cfg_reg[b][1] <= dsg_pkg::PIN1_RST;
        cfg_reg[b][2] <= dsg_pkg::PIN2_RST;
        cfg_reg[b][3] <= dsg_pkg::PIN3_RST;
      end
      sel_reg       <= 1'b0;
      irq_st_reg    <= '0;
      irq_en_reg    <= '0;
      prev_lock_reg <= 1'b0;
      prev_sig_reg  <= 1'b0;
    end else begin
      cfg_reg       <= cfg_next;
      sel_reg       <= sel_next;
      irq_st_reg    <= irq_st_next;
      irq_en_reg    <= irq_en_next;
      prev_lock_reg <= gen_status[dsg_pkg::ST_LOCK_BIT];
      prev_sig_reg  <= gen_status[dsg_pkg::ST_SIGDET_BIT];
    end
  end

  assign irq = |(irq_st_reg & irq_en_reg);

  // Frequency counter
  typedef enum logic {DSG_FC_IDLE, DSG_FC_COUNT} dsg_fc_state_t;
  dsg_fc_state_t fc_state_reg, fc_state_next;
  logic [7:0]    interval_reg, interval_next;
  logic [7:0]    edges_reg, edges_next;
  logic [$clog2(dsg_pkg::OSC_CYCLES+1)-1:0] osc_div_reg, osc_div_next;
  logic          osc_tick;

  always_comb begin
    fc_state_next = fc_state_reg;
    interval_next = interval_reg;
    edges_next    = edges_reg;
    osc_div_next  = osc_div_reg;
    freq_done     = 1'b0;
    osc_tick      = (osc_div_reg == '0);
    case (fc_state_reg)
      DSG_FC_IDLE: begin
        osc_div_next = '0;
      end
      DSG_FC_COUNT: begin
        if (pix_edge && edges_reg != 8'hff) begin
          edges_next = edges_reg + 8'h01;
        end
        // Oscillator period divider
        osc_div_next = osc_tick ? 
          ($bits(osc_div_reg))'(dsg_pkg::OSC_CYCLES - 1) : osc_div_reg - 1'b1;
        if (osc_tick) begin
          interval_next = interval_reg - 8'h01;
          if (interval_reg == 8'h01) begin
            fc_state_next = DSG_FC_IDLE;
            freq_done     = 1'b1;
          end
        end
      end
      default: fc_state_next = DSG_FC_IDLE;
    endcase
    if (wr_to(dsg_pkg::IDX_FREQ_COUNT)) begin
      edges_next    = 8'h00;
      interval_next = wdata_reg;
      osc_div_next  = ($bits(osc_div_reg))'(dsg_pkg::OSC_CYCLES - 1);
      fc_state_next = (wdata_reg == 8'h00) ? DSG_FC_IDLE : DSG_FC_COUNT;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fc_state_reg <= DSG_FC_IDLE;
      interval_reg <= 8'h00;
      edges_reg    <= 8'h00;
      osc_div_reg  <= '0;
    end else begin
      fc_state_reg <= fc_state_next;
      interval_reg <= interval_next;
      edges_reg    <= edges_next;
      osc_div_reg  <= osc_div_next;
    end
  end

  // AXI4-Lite read channel
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [5:0]  ridx;

  always_comb begin
    s_axi_arready = ~rvalid_reg;
    ridx          = reg_index(s_axi_araddr);
    rvalid_next   = rvalid_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next  = '0;
      rresp_next  = dsg_pkg::RESP_OKAY;
      case (ridx)
        dsg_pkg::IDX_FREQ_COUNT: rdata_next[7:0] = edges_reg;
        dsg_pkg::IDX_GEN_STATUS: rdata_next[7:0] = gen_status;
        dsg_pkg::IDX_PIN0_CFG:   rdata_next[7:0] = {REVISION, cfg_reg[sel_reg][0]};
        dsg_pkg::IDX_PIN12_CFG:  rdata_next[7:0] = {cfg_reg[sel_reg][2], cfg_reg[sel_reg][1]};
        dsg_pkg::IDX_PIN3_CFG:   rdata_next[7:0] = {4'h0, cfg_reg[sel_reg][3]};
        dsg_pkg::IDX_PORT_SEL:   rdata_next[0]   = sel_reg;
        dsg_pkg::IDX_IRQ_STATUS: rdata_next[dsg_pkg::EV_W-1:0] = irq_st_reg;
        dsg_pkg::IDX_IRQ_CLEAR:  rdata_next      = '0;
        dsg_pkg::IDX_IRQ_ENABLE: rdata_next[dsg_pkg::EV_W-1:0] = irq_en_reg;
        dsg_pkg::IDX_PIN_LEVELS: rdata_next[7:0] = pad_s2_reg;
        default:                 rresp_next      = dsg_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= 2'h0;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // Pad drivers, one per pin of both ports
  logic [7:0] pad_out_reg, pad_out_next;
  logic [7:0] pad_oe_reg, pad_oe_next;

  for (genvar i = 0; i < 8; i++) begin : g_pad
    dsg_pkg::dsg_pin_cfg_t c;
    assign c = cfg_reg[i / 4][i % 4];
    always_comb begin
      if (c.remote_control) begin
        pad_oe_next[i]  = 1'b1;
        pad_out_next[i] = remote_value[i];
      end else begin
        case ({c.direction, c.function_enable})
          2'b00: begin
            pad_oe_next[i]  = 1'b1;
            pad_out_next[i] = functional_value[i];
          end
          2'b01: begin
            pad_oe_next[i]  = 1'b1;
            pad_out_next[i] = c.local_value;
          end
          default: begin
            pad_oe_next[i]  = 1'b0;
            pad_out_next[i] = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_reg <= 8'h00;
      pad_oe_reg  <= 8'h00;
    end else begin
      pad_out_reg <= pad_out_next;
      pad_oe_reg  <= pad_oe_next;
    end
  end

  assign pad_out = pad_out_reg;
  assign pad_oe  = pad_oe_reg;

endmodule

// *** verif/dsg_properties.sv ***
// Checker for the status and pin register bank.
// Bound into dsg_regs; sees its ports only.
`timescale 1ns/1ps

module dsg_properties #(
  parameter int unsigned ADDR_W   = 8,
  parameter logic [3:0]  REVISION = 4'ha  // Arbitrary value
) (
  // Clock and reset
  input wire logic                      aclk,
  input wire logic                      aresetn,
  // Bus handshakes and answers
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic [ADDR_W-1:0]         s_axi_araddr,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic [1:0]                s_axi_rresp,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  // Status inputs and pad enables
  input wire dsg_pkg::dsg_link_status_t link_status,
  input wire logic [7:0]                pad_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Status word expected from the link inputs
  function automatic logic [31:0] st_exp(dsg_pkg::dsg_link_status_t s);
    return {26'h0, s.transmit_two_link_flag, s.receive_two_link_flag, s.audio_pll_locked,
            1'b0, s.serial_detect, s.lock_ch_a & (s.lock_ch_b | ~s.receive_two_link_flag)};
  endfunction

  // Handshake steps
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken(logic [5:0] idx);
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == idx;
  endsequence
  sequence link_steady;
    $stable(link_status) [*4];
  endsequence

  // Register contents seen on reads
  status_read_a: assert property (
    link_steady ##0 rd_taken(dsg_pkg::IDX_GEN_STATUS) |=> s_axi_rdata == st_exp($past(link_status)))
    else $error("status word differs from link inputs");
  revision_read_a: assert property (
    rd_taken(dsg_pkg::IDX_PIN0_CFG) |=> s_axi_rdata[31:4] == {24'h0, REVISION})
    else $error("revision field wrong");
  unmapped_read_a: assert property (
    rd_taken(6'h3f) |=> s_axi_rresp == dsg_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Pad enables move only after a register write, once two cycles out of reset
  pad_cause_a: assert property (
    $changed(pad_oe) && $past(aresetn, 2) && $past(aresetn)
      |-> $past(s_axi_bvalid))
    else $error("pad enable changed without a write");
  // Bus answers and holds
  write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read answer late");
endmodule

bind dsg_regs dsg_properties #(.ADDR_W(ADDR_W), .REVISION(REVISION)) props_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .link_status(link_status), .pad_oe(pad_oe));

// *** verif/dsg_remote_ser.sv ***
// Model of the remote serializer: remote pin values and the pixel clock.
// Steered by the bench on the register clock.
`timescale 1ns/1ps

module dsg_remote_ser (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Steering from the bench
  input wire logic       run,   // Pixel clock runs
  input wire logic [3:0] half,  // Half period in clock cycles
  input wire logic       hop,   // Step the remote values
  // Link side
  output logic [7:0]     remote_value,
  output logic           pixel_clock
);
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] val_next;
  logic       pix_next;

  // Pixel clock low when stopped; remote values step
  always_comb begin
    cnt_next = cnt_reg + 4'h1;
    pix_next = pixel_clock;
    if (!run) begin
      cnt_next = 4'h0;
      pix_next = 1'b0;
    end else if (cnt_next >= half) begin
      cnt_next = 4'h0;
      pix_next = !pixel_clock;
    end
    val_next = hop ? {remote_value[6:0], ~(remote_value[7] ^ remote_value[5])} : remote_value;
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 4'h0;
      pixel_clock <= 1'b0;
      remote_value <= 8'h5a;
    end else begin
      cnt_reg <= cnt_next;
      pixel_clock <= pix_next;
      remote_value <= val_next;
    end
  end
endmodule

// *** verif/dsg_tb.sv ***
// Self-checking bench for the status and pin register bank.
// Assumes an 8-bit byte address and the remote serializer model.
`timescale 1ns/1ps

module testbench;
  localparam logic [3:0] REV = 4'h6;  // Arbitrary revision value
  // Bench driven inputs
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, run = 1'b1, hop = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0, fv = 8'h0, pin = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  half = 4'h1;
  dsg_pkg::dsg_link_status_t ls = '0;
  // Design and partner outputs
  logic        awready, wready, bvalid, arready, rvalid, irq, pix;
  logic [1:0]  bresp, rresp, br;
  logic [31:0] rdata;
  logic [7:0]  rv, pad_out, pad_oe;
  // Bench state
  logic [3:0]  cfg [8];
  int          failures = 0;
  int          tests_run = 0;
  int          seed = 32'hcad7;

  always #50 aclk = ~aclk;

  dsg_regs #(.REVISION(REV)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_status(ls), .pixel_clock(pix), .functional_value(fv), .remote_value(rv),
    .pad_in(pin), .pad_out(pad_out), .pad_oe(pad_oe), .irq(irq));
  dsg_remote_ser ser (.aclk(aclk), .aresetn(aresetn), .run(run), .half(half), .hop(hop),
    .remote_value(rv), .pixel_clock(pix));

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Bus write
  task automatic axw(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'($random(seed)), d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      r = bresp;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  // Bus read
  task automatic axr(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      d = rdata;
      r = rresp;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    axr(idx, d, br);
    chk(name, d, exp);
  endtask

  // Expected status word and pad behaviour {oe, out}
  function automatic logic [31:0] st_exp(dsg_pkg::dsg_link_status_t s);
    return {26'h0, s.transmit_two_link_flag, s.receive_two_link_flag, s.audio_pll_locked,
            1'b0, s.serial_detect, s.lock_ch_a & (s.lock_ch_b | ~s.receive_two_link_flag)};
  endfunction
  function automatic logic [1:0] pad_exp(logic [3:0] c, logic f, logic v);
    if (c[2]) return {1'b1, v};
    case (c[1:0])
      2'b00: return {1'b1, f};
      2'b01: return {1'b1, c[3]};
      default: return 2'b00;
    endcase
  endfunction

  task automatic pads_chk();
    logic [7:0] eo, ev;
    logic [1:0] p;
    for (int k = 0; k < 8; k++) begin
      p = pad_exp(cfg[k], fv[k], rv[k]);
      eo[k] = p[1];
      ev[k] = p[0];
    end
    chk("pad_oe", 32'(pad_oe), 32'(eo));
    chk("pad_out", 32'(pad_out & eo), 32'(ev & eo));
  endtask

  // Frequency measurement with optional restart
  task automatic freq_run(input logic [7:0] n, input logic [3:0] h, input logic [7:0] pre,
                          input int exp);
    int t;
    @(posedge aclk);
    half <= h;
    repeat (16) @(posedge aclk);
    if (pre != 8'h0) axw(dsg_pkg::IDX_FREQ_COUNT, pre, br);
    repeat (10) @(posedge aclk);
    axw(dsg_pkg::IDX_FREQ_COUNT, n, br);
    t = 0;
    while (irq !== 1'b1 && t < 400) begin
      @(posedge aclk);
      t++;
    end
    chk("freq_done", 32'(irq), 32'(n != 8'h0));
    rchk("freq_count", dsg_pkg::IDX_FREQ_COUNT, 32'(exp));
    axw(dsg_pkg::IDX_IRQ_CLEAR, 8'h04, br);
  endtask

  // Watchdog
  initial begin
    #(100 * 40000);
    failures++;
    summarize();
  end

  initial begin : main
    logic [31:0] d;
    logic [7:0]  b;
    int          p;
    for (int k = 0; k < 8; k++) cfg[k] = (k % 4 == 2) ? 4'h0 : (k % 4 == 3) ? 4'h2 : 4'h3;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    // Reset contents and pads
    pads_chk();
    rchk("status", dsg_pkg::IDX_GEN_STATUS, 32'h0);
    rchk("pin0", dsg_pkg::IDX_PIN0_CFG, {24'h0, REV, 4'h3});
    rchk("pin12", dsg_pkg::IDX_PIN12_CFG, 32'h3);
    rchk("pin3", dsg_pkg::IDX_PIN3_CFG, 32'h2);
    rchk("freq", dsg_pkg::IDX_FREQ_COUNT, 32'h0);
    // Link status corners, then random; pad levels
    for (int k = 0; k < 12; k++) begin
      @(posedge aclk);
      ls <= (k == 0) ? 6'h11 : (k == 1) ? 6'h13 : 6'($random(seed));
      pin <= 8'($random(seed));
      repeat (4) @(posedge aclk);
      rchk("status", dsg_pkg::IDX_GEN_STATUS, st_exp(ls));
      rchk("pad_in", dsg_pkg::IDX_PIN_LEVELS, 32'(pin));
    end
    axw(dsg_pkg::IDX_GEN_STATUS, 8'hff, br);
    rchk("status_ro", dsg_pkg::IDX_GEN_STATUS, st_exp(ls));
    // Every pin code on both pin ports
    for (int k = 0; k < 32; k++) begin
      p = (k / 16) * 4;
      axw(dsg_pkg::IDX_PORT_SEL, 8'(k / 16), br);
      b = 8'($random(seed));
      axw(dsg_pkg::IDX_PIN0_CFG, b, br);
      cfg[p] = b[3:0];
      rchk("pin0", dsg_pkg::IDX_PIN0_CFG, {24'h0, REV, b[3:0]});
      b = {4'($random(seed)), 4'(k)};
      axw(dsg_pkg::IDX_PIN12_CFG, b, br);
      cfg[p + 1] = b[3:0];
      cfg[p + 2] = b[7:4];
      rchk("pin12", dsg_pkg::IDX_PIN12_CFG, 32'(b));
      b = {4'h0, 4'($random(seed))};
      axw(dsg_pkg::IDX_PIN3_CFG, b, br);
      cfg[p + 3] = b[3:0];
      rchk("pin3", dsg_pkg::IDX_PIN3_CFG, 32'(b));
      fv <= 8'($random(seed));
      hop <= 1'b1;
      @(posedge aclk);
      hop <= 1'b0;
      repeat (3) @(posedge aclk);
      pads_chk();
    end
    // Unmapped place refused
    axw(6'h3f, 8'h55, br);
    chk("wr_resp", 32'(br), 32'(dsg_pkg::RESP_SLVERR));
    axr(6'h3f, d, br);
    chk("rd_resp", 32'(br), 32'(dsg_pkg::RESP_SLVERR));
    chk("rd_data", d, 32'h0);
    // Interrupt masked, then enabled, then cleared
    axw(dsg_pkg::IDX_IRQ_CLEAR, 8'h07, br);
    axw(dsg_pkg::IDX_FREQ_COUNT, 8'h10, br);
    repeat (40) @(posedge aclk);
    chk("irq_masked", 32'(irq), 32'h0);
    rchk("irq_status", dsg_pkg::IDX_IRQ_STATUS, 32'h4);
    rchk("freq", dsg_pkg::IDX_FREQ_COUNT, 32'h8);
    axw(dsg_pkg::IDX_IRQ_ENABLE, 8'h04, br);
    repeat (2) @(posedge aclk);
    chk("irq_on", 32'(irq), 32'h1);
    axw(dsg_pkg::IDX_IRQ_CLEAR, 8'h04, br);
    repeat (2) @(posedge aclk);
    chk("irq_off", 32'(irq), 32'h0);
    // Interval lengths, a zero interval and a restart
    freq_run(8'hfe, 4'h1, 8'h0, 127);
    freq_run(8'h50, 4'h2, 8'h0, 20);
    freq_run(8'h0c, 4'h3, 8'h0, 2);
    freq_run(8'h00, 4'h1, 8'h0, 0);
    freq_run(8'h14, 4'h1, 8'hc8, 10);
    @(posedge aclk);
    run <= 1'b0;
    freq_run(8'h14, 4'h1, 8'h0, 0);
    summarize();
  end
endmodule
